// ### src/flash_sp_device.sv
/*
  Flash self-programming sequencer, device end: control register, four
  cycle store window, temporary page buffer, page erase and page write
  with region blocking and CPU halt, ready interrupt and a flash read port.
  Assumes a core end on the same clock driving the interface, a level
  from the EEPROM controller and the boot lock bit from fuse logic.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "flash_sp_consts.svh"
module flash_sp_device #(
  parameter int WB = 5, // Word-in-page bits
  parameter int PB = 7, // Page index bits
  parameter int NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 96, // First page of the halting region
  parameter int BLS_FIRST_PAGE = 112, // First page of the boot loader section
  parameter logic [19:0] PROG_CYCLES = `PROG_CYCLES_DEF // Erase or write time
) (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  flash_sp_if.dev link, // Core side
  input wire logic eeprom_busy, // EEPROM write in progress
  input wire logic boot_lock11 // Boot lock bit, 1 = unprogrammed
);
  localparam int PAGE_WORDS = 1 << WB;
  localparam int AW = WB + PB;
  localparam int FLASH_WORDS = 1 << AW;

  typedef struct packed {
    flash_sp_pkg::dev_state_t state;
    logic irq_en;
    logic [4:0] ctl;
    logic region_busy;
    logic [2:0] win;
    logic [PB-1:0] op_page;
    logic [19:0] timer;
    logic halt;
    logic loaded;
    logic [PAGE_WORDS-1:0][15:0] pbuf;
    logic do_erase;
    logic do_write;
    logic [7:0] status;
    logic irq;
    logic rd_valid;
    logic rd_blocked;
  } dev_reg_t;

  dev_reg_t s;
  dev_reg_t next_s;
  logic [15:0] flash [FLASH_WORDS];
  logic [15:0] rd_word;
  logic rd_hits_busy;
  logic [PB-1:0] ptr_page;
  logic [WB-1:0] ptr_word;

  // Only the five defined patterns arm the store window
  function automatic logic cmd_legal(input logic [4:0] c);
    return (c == `CMD_LOAD) || (c == `CMD_ERASE) || (c == `CMD_WRITE) ||
           (c == `CMD_LOCK) || (c == `CMD_REREAD);
  endfunction : cmd_legal

  // Pages below the halting region form the read-while-write region
  function automatic logic page_is_rww(input logic [PB-1:0] p);
    return 32'(p) < NO_READ_WHILE_WRITE_REGION_FIRST_PAGE;
  endfunction : page_is_rww

  // Byte pointer split into page index and word in page
  assign ptr_page = link.addr_ptr[PB+WB:WB+1];
  assign ptr_word = link.addr_ptr[WB:1];
  assign rd_hits_busy = s.region_busy && page_is_rww(link.rd_addr[AW-1:WB]);

  // Next state of the whole sequencer
  always_comb begin
    next_s = s;
    next_s.do_erase = 1'b0;
    next_s.do_write = 1'b0;

    // Buffer empties on the same edge as the flash takes its contents
    if (s.do_write) begin
      next_s.pbuf = {PAGE_WORDS{`ERASED_WORD}};
      next_s.loaded = 1'b0;
    end

    // EEPROM activity ruins a partly loaded buffer; stores are refused too
    if (eeprom_busy && s.loaded) begin
      next_s.pbuf = {PAGE_WORDS{`ERASED_WORD}};
      next_s.loaded = 1'b0;
    end

    // Interrupt enable is always writable, command bits only when not busy
    if (link.ctl_wr) begin
      next_s.irq_en = link.ctl_wdata[`CTL_IRQ_EN];
    end

    case (s.state)
      flash_sp_pkg::DEV_IDLE,
      flash_sp_pkg::DEV_ARMED: begin
        if (link.ctl_wr) begin
          if (cmd_legal(link.ctl_wdata[4:0])) begin
            next_s.ctl = link.ctl_wdata[4:0];
            next_s.win = `SPM_WINDOW;
            next_s.state = flash_sp_pkg::DEV_ARMED;
          end
          // Other low patterns leave everything as it was
        end else if (s.state == flash_sp_pkg::DEV_ARMED) begin
          if (link.spm_exec && !eeprom_busy) begin
            next_s.state = flash_sp_pkg::DEV_IDLE;
            next_s.ctl = 5'h00;
            case (s.ctl)
              `CMD_LOAD: begin
                // One word per store, any order
                next_s.pbuf[ptr_word] = link.data_pair;
                next_s.loaded = 1'b1;
                next_s.region_busy = 1'b0;
              end
              `CMD_ERASE,
              `CMD_WRITE: begin
                // Boot section is guarded by the lock bit
                if (boot_lock11 || (32'(ptr_page) < BLS_FIRST_PAGE)) begin
                  next_s.state = flash_sp_pkg::DEV_BUSY;
                  next_s.ctl = s.ctl;
                  next_s.op_page = ptr_page;
                  next_s.timer = PROG_CYCLES;
                  if (page_is_rww(ptr_page)) begin
                    next_s.region_busy = 1'b1;
                  end else begin
                    next_s.halt = 1'b1;
                  end
                end
              end
              `CMD_REREAD: begin
                next_s.region_busy = 1'b0;
                next_s.pbuf = {PAGE_WORDS{`ERASED_WORD}};
                next_s.loaded = 1'b0;
              end
              default: begin
                // Lock bit setting is handled elsewhere; the store is consumed
                next_s.ctl = 5'h00;
              end
            endcase
          end else if (s.win == 3'h1) begin
            // No store came within the window
            next_s.ctl = 5'h00;
            next_s.state = flash_sp_pkg::DEV_IDLE;
          end else begin
            next_s.win = s.win - 3'h1;
          end
        end
      end
      flash_sp_pkg::DEV_BUSY: begin
        // Store enable stays up for the whole operation
        if (s.timer == 20'h00001) begin
          next_s.do_erase = s.ctl[`CTL_ERASE];
          next_s.do_write = s.ctl[`CTL_WRITE];
          next_s.ctl = 5'h00;
          next_s.halt = 1'b0;
          next_s.state = flash_sp_pkg::DEV_IDLE;
        end else begin
          next_s.timer = s.timer - 20'h00001;
        end
      end
      default: begin
        next_s.state = flash_sp_pkg::DEV_IDLE;
      end
    endcase

    // Readback and interrupt follow the state being registered
    next_s.status = {next_s.irq_en, next_s.region_busy, 1'b0, next_s.ctl};
    next_s.irq = next_s.irq_en && !next_s.ctl[`CTL_STORE_EN];
    next_s.rd_valid = link.rd_en;
    next_s.rd_blocked = link.rd_en && rd_hits_busy;
  end

  // All sequencer state in one register; the buffer resets erased
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pbuf <= {PAGE_WORDS{`ERASED_WORD}};
      s.status <= `CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Flash array; a blocked read returns erased data instead of the array
  always_ff @(posedge mclk) begin
    if (s.do_erase) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash[{s.op_page, WB'(i)}] <= `ERASED_WORD;
      end
    end
    if (s.do_write) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        // Programming only pulls bits low, so an unerased page mixes data
        flash[{s.op_page, WB'(i)}] <= flash[{s.op_page, WB'(i)}] & s.pbuf[i];
      end
    end
  end

  // Read data register; held when no read is asked
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_word <= `ERASED_WORD;
    end else if (link.rd_en) begin
      rd_word <= rd_hits_busy ? `ERASED_WORD : flash[link.rd_addr];
    end
  end

  assign link.ctl_rdata = s.status;
  assign link.ready_irq = s.irq;
  assign link.cpu_halt = s.halt;
  assign link.rd_data = rd_word;
  assign link.rd_valid = s.rd_valid;
  assign link.rd_blocked = s.rd_blocked;

endmodule : flash_sp_device
`default_nettype wire

// ### src/flash_sp_consts.svh
/*
  Shared constants of the flash self-programming sequencer: control bit
  positions, command patterns, timing counts and the offsets of the core
  end's software registers. Assumes inclusion by bare name from src/.
*/
// What this block does
// - Software erases a page before writing it
// - Buffer loads one word per store instruction
// - Buffer words load in any address order
// - Erase and write use the same page
// - Erase pattern plus store within four cycles
// - Erase takes only the page index field
// - Erase blocks region or halts the CPU
// - No interrupts inside the timed sequence
// - Load pattern plus store fills buffer word
// - Buffer clears on write, re-enable, reset
// - Each buffer word written once per clear
// - EEPROM write during loading discards buffer
// - Write pattern plus store programs the page
// - Page write pointer holds only page bits
// - Writing read-while-write region keeps other readable
// - Writing the other region halts the CPU
// - Ready interrupt asserted while store enable clear
// - Vectors live in the boot loader section; here the ready request is only polled, never vectored
// - Boot section writable only while lock unprogrammed
// - Store enable lasts four cycles then clears
// - Store enable stays set until operation ends
// - Region busy flag set, cleared by re-enable/load
// - Undefined low control patterns do nothing
`ifndef FLASH_SP_CONSTS_SVH
`define FLASH_SP_CONSTS_SVH

// Control register bit positions
`define CTL_STORE_EN 0
`define CTL_ERASE 1
`define CTL_WRITE 2
`define CTL_LOCK 3
`define CTL_REREAD 4
`define CTL_BUSY 6
`define CTL_IRQ_EN 7

// Low five bit command patterns
`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_REREAD 5'h11

// Values and timing
`define CTL_RESET 8'h00
`define ERASED_WORD 16'hffff
`define SPM_WINDOW 3'h4
`define PROG_CYCLES_DEF 20'h007d0

// Core end software register offsets
`define HREG_PTR 3'h0
`define HREG_DATA 3'h1
`define HREG_CTL 3'h2
`define HREG_STATUS 3'h3
`define HREG_RADDR 3'h4
`define HREG_RDATA 3'h5
`define HREG_SEQ 3'h6

`endif

// ### src/flash_sp_pkg.sv
/*
  Types of the flash self-programming sequencer: state enumerations of
  both ends. Assumes nothing of its surroundings.
*/
package flash_sp_pkg;

  // Device sequencer state, Gray along idle, armed, busy
  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_ARMED = 2'h1,
    DEV_BUSY = 2'h3
  } dev_state_t;

  // Core command sequence state, Gray along the usual path
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_CTL = 2'h1,
    SEQ_GAP = 2'h3,
    SEQ_STORE = 2'h2
  } seq_state_t;

endpackage : flash_sp_pkg

// ### src/flash_sp_if.sv
/*
  Link between the processor core end and the flash sequencer end.
  Assumes both ends run on the same clock; the testbench joins them.
*/
`timescale 1ns/1ns
`default_nettype none
interface flash_sp_if #(
  parameter int AW = 12 // Flash word address width
);
  logic ctl_wr; // Control register write strobe
  logic [7:0] ctl_wdata; // Control register write value
  logic [7:0] ctl_rdata; // Control register readback
  logic spm_exec; // Store program instruction pulse
  logic [15:0] addr_ptr; // Flash address pointer, byte address
  logic [15:0] data_pair; // Data register pair
  logic rd_en; // Flash word read request
  logic [AW-1:0] rd_addr; // Flash word read address
  logic [15:0] rd_data; // Flash word read data
  logic rd_valid; // Read data valid pulse
  logic rd_blocked; // Read hit the busy region
  logic ready_irq; // Store ready interrupt request
  logic cpu_halt; // Core must stall

  modport dev (
    input ctl_wr, ctl_wdata, spm_exec, addr_ptr, data_pair, rd_en, rd_addr,
    output ctl_rdata, rd_data, rd_valid, rd_blocked, ready_irq, cpu_halt
  );
  modport core (
    output ctl_wr, ctl_wdata, spm_exec, addr_ptr, data_pair, rd_en, rd_addr,
    input ctl_rdata, rd_data, rd_valid, rd_blocked, ready_irq, cpu_halt
  );
endinterface : flash_sp_if
`default_nettype wire

// ### src/flash_sp_core.sv
/*
  Processor core end of the flash sequencer: software registers for the
  pointer, data pair and commands, issuing each command as a control write
  followed by a store within the window, and flash reads.
  Assumes the device end on the same clock and software on a plain port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "flash_sp_consts.svh"
module flash_sp_core #(
  parameter int WB = 5, // Word-in-page bits
  parameter int PB = 7, // Page index bits
  parameter logic [1:0] SPM_GAP = 2'h2 // Gap state cycles, 1..3; the store comes SPM_GAP + 1 cycles after the control write
) (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  flash_sp_if.core link, // Device side
  input wire logic [2:0] sw_addr, // Register offset
  input wire logic [15:0] sw_wdata, // Write data
  input wire logic sw_wr, // Write strobe
  input wire logic sw_rd, // Read strobe
  output logic [15:0] sw_rdata // Read data, cycle after the strobe
);
  localparam int PAGE_WORDS = 1 << WB;
  localparam int AW = WB + PB;

  typedef struct packed {
    flash_sp_pkg::seq_state_t seq;
    logic [1:0] gap;
    logic [15:0] ptr;
    logic [15:0] data;
    logic [7:0] cmd;
    logic [15:0] rdata;
    logic [15:0] flash_word;
    logic [PAGE_WORDS-1:0] written;
    logic erased_ok;
    logic [PB-1:0] erased_page;
    logic refused;
    logic ctl_wr;
    logic [7:0] ctl_wdata;
    logic spm_exec;
    logic [15:0] addr_ptr;
    logic [15:0] data_pair;
    logic rd_en;
    logic [AW-1:0] rd_addr;
  } core_reg_t;

  core_reg_t s;
  core_reg_t next_s;
  logic [PB-1:0] sw_page;
  logic [WB-1:0] sw_word;

  assign sw_page = s.ptr[PB+WB:WB+1];
  assign sw_word = s.ptr[WB:1];

  // Command issue and register port; no interrupt can split the sequence
  always_comb begin
    next_s = s;
    next_s.ctl_wr = 1'b0;
    next_s.spm_exec = 1'b0;
    next_s.rd_en = 1'b0;
    if (link.rd_valid) begin
      next_s.flash_word = link.rd_data;
    end
    case (s.seq)
      flash_sp_pkg::SEQ_IDLE: begin
        if (sw_wr && !link.cpu_halt) begin
          case (sw_addr)
            `HREG_PTR: next_s.ptr = sw_wdata;
            `HREG_DATA: next_s.data = sw_wdata;
            `HREG_RADDR: begin
              next_s.rd_en = 1'b1;
              next_s.rd_addr = sw_wdata[AW-1:0];
            end
            `HREG_CTL: begin
              next_s.refused = 1'b0;
              next_s.cmd = sw_wdata[7:0];
              next_s.addr_ptr = s.ptr;
              if (sw_wdata[4:0] == `CMD_WRITE) begin
                // Only the erased page may be written
                next_s.refused = !(s.erased_ok && s.erased_page == sw_page);
                next_s.addr_ptr = 16'({sw_page, {(WB+1){1'b0}}});
              end else if (sw_wdata[4:0] == `CMD_LOAD) begin
                next_s.refused = s.written[sw_word];
              end
              if (!next_s.refused) begin
                next_s.seq = flash_sp_pkg::SEQ_CTL;
              end
            end
            default: begin
            end
          endcase
        end
      end
      flash_sp_pkg::SEQ_CTL: begin
        next_s.ctl_wr = 1'b1;
        next_s.ctl_wdata = s.cmd;
        next_s.data_pair = s.data;
        next_s.gap = SPM_GAP;
        next_s.seq = flash_sp_pkg::SEQ_GAP;
      end
      flash_sp_pkg::SEQ_GAP: begin
        if (s.gap == 2'h1) begin
          next_s.seq = flash_sp_pkg::SEQ_STORE;
        end else begin
          next_s.gap = s.gap - 2'h1;
        end
      end
      flash_sp_pkg::SEQ_STORE: begin
        next_s.spm_exec = 1'b1;
        next_s.seq = flash_sp_pkg::SEQ_IDLE;
        case (s.cmd[4:0])
          `CMD_LOAD: next_s.written[sw_word] = 1'b1;
          `CMD_ERASE: begin
            next_s.erased_ok = 1'b1;
            next_s.erased_page = sw_page;
          end
          `CMD_WRITE,
          `CMD_REREAD: begin
            next_s.written = '0;
            next_s.erased_ok = 1'b0;
          end
          default: begin
          end
        endcase
      end
      default: begin
        next_s.seq = flash_sp_pkg::SEQ_IDLE;
      end
    endcase
    // Register reads answer one cycle after the strobe; the ready request is only
    // polled here, never vectored, so no fetch can touch a blocked region
    next_s.rdata = 16'h0000;
    if (sw_rd) begin
      case (sw_addr)
        `HREG_PTR: next_s.rdata = s.ptr;
        `HREG_DATA: next_s.rdata = s.data;
        `HREG_STATUS: next_s.rdata = {8'h00, link.ctl_rdata};
        `HREG_RDATA: next_s.rdata = s.flash_word;
        `HREG_SEQ: next_s.rdata = {11'h000, link.ready_irq, link.cpu_halt,
                                   s.refused, s.erased_ok, s.seq != flash_sp_pkg::SEQ_IDLE};
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sw_rdata = s.rdata;
  assign link.ctl_wr = s.ctl_wr;
  assign link.ctl_wdata = s.ctl_wdata;
  assign link.spm_exec = s.spm_exec;
  assign link.addr_ptr = s.addr_ptr;
  assign link.data_pair = s.data_pair;
  assign link.rd_en = s.rd_en;
  assign link.rd_addr = s.rd_addr;

endmodule : flash_sp_core
`default_nettype wire

// ### tb/flash_sp_checker.sv
/*
  Checker of the link between core and flash sequencer: control bits,
  store window, busy span, reads, halt and ready request.
  Assumes the bench instantiates it beside the interface, same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "flash_sp_consts.svh"
module flash_sp_checker #(
  parameter int NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 96 // First halting page
) (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic ctl_wr, // Control write
  input wire logic [7:0] ctl_wdata, // Control value
  input wire logic [7:0] ctl_rdata, // Control readback
  input wire logic spm_exec, // Store pulse
  input wire logic eeprom_busy, // EEPROM write
  input wire logic rd_en, // Read request
  input wire logic [11:0] rd_addr, // Read address
  input wire logic [15:0] rd_data, // Read data
  input wire logic rd_valid, // Read valid
  input wire logic rd_blocked, // Read blocked
  input wire logic ready_irq, // Ready request
  input wire logic cpu_halt // Core stall
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  logic legal;
  logic rww_busy;
  // Helpers: defined pattern, and a read that lands in the blocked region
  assign legal = ctl_wdata[4:0] inside {`CMD_LOAD, `CMD_ERASE, `CMD_WRITE, `CMD_LOCK, `CMD_REREAD};
  assign rww_busy = ctl_rdata[6] && (rd_addr[11:5] < NO_READ_WHILE_WRITE_REGION_FIRST_PAGE);

  a_illegal_ignored: assert property (ctl_wr && !ctl_rdata[0] && !legal |=> ctl_rdata[4:0] == 5'h00)
    else $error("undefined pattern changed control bits");
  a_cmd_arms: assert property (ctl_wr && !ctl_rdata[0] && legal
    |=> ctl_rdata[4:0] == $past(ctl_wdata[4:0]))
    else $error("command not armed");
  a_window_ends: assert property (ctl_wr && !ctl_rdata[0] && legal ##1
    (!ctl_wr && (!spm_exec || eeprom_busy)) [*4] |=> !ctl_rdata[0])
    else $error("store enable outlived its window");
  // Eight busy cycles match the bench's program time of eight
  a_busy_span: assert property ($rose(ctl_rdata[6]) |-> ctl_rdata[0] [*8] ##1 !ctl_rdata[0])
    else $error("store enable span wrong");
  a_halt_in_op: assert property (cpu_halt |-> ctl_rdata[0] || $past(ctl_rdata[0]))
    else $error("halt outside an operation");
  a_read_free: assert property (rd_en && !rww_busy |=> rd_valid && !rd_blocked)
    else $error("free read not answered");
  a_read_blocked: assert property (rd_en && rww_busy
    |=> rd_valid && rd_blocked && rd_data == `ERASED_WORD)
    else $error("busy region read not blocked");
  a_irq_on: assert property ((ctl_rdata[7] && !ctl_rdata[0]) [*2] |-> ready_irq)
    else $error("ready request missing");
  a_irq_off: assert property (ctl_rdata[0] [*2] |-> !ready_irq)
    else $error("ready request while store enabled");

  // Main scenarios seen
  c_busy: cover property ($rose(ctl_rdata[6]));
  c_halt: cover property ($rose(cpu_halt));
  c_blocked: cover property (rd_blocked);
  c_irq: cover property (ready_irq);
endmodule : flash_sp_checker
`default_nettype wire

// ### tb/flash_self_program_sequencer_bench.sv
/*
  Bench of core and sequencer joined by the link: fills, erases, writes,
  read blocking, buffer discard paths, halt, boot lock, patterns, irq.
  Assumes the design sources under src/ and a short program time.
*/
`timescale 1ns/1ns
`default_nettype none
`include "flash_sp_consts.svh"
module flash_self_program_sequencer_bench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic eeprom_busy = 1'b0;
  logic boot_lock11 = 1'b1;
  int fails = 0;
  int num_checks = 0;
  int halt_cycles = 0;
  int modes [5] = '{0, 3, 1, 2, 4};
  int ill [4] = '{2, 7, 31, 19};
  logic [15:0] exp_mem [32];

  // Geometry and gap stay at their defaults; only the program time is shortened
  flash_sp_if link ();
  flash_sp_device #(.PROG_CYCLES(20'h00008)) u_flash_sp_device (.mclk(mclk), .reset_n(reset_n), .link(link),
    .eeprom_busy(eeprom_busy), .boot_lock11(boot_lock11));
  flash_sp_core u_flash_sp_core (.mclk(mclk), .reset_n(reset_n), .link(link), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  flash_sp_checker u_flash_sp_checker (.mclk(mclk), .reset_n(reset_n),
    .ctl_wr(link.ctl_wr), .ctl_wdata(link.ctl_wdata), .ctl_rdata(link.ctl_rdata), .spm_exec(link.spm_exec),
    .eeprom_busy(eeprom_busy), .rd_en(link.rd_en), .rd_addr(link.rd_addr), .rd_data(link.rd_data),
    .rd_valid(link.rd_valid), .rd_blocked(link.rd_blocked), .ready_irq(link.ready_irq), .cpu_halt(link.cpu_halt));

  // Clock, 50 ns period
  always #25 mclk = ~mclk;
  // Halt cycles since the last clear
  always @(posedge mclk) begin
    if (link.cpu_halt === 1'b1) halt_cycles <= halt_cycles + 1;
  end

  function automatic logic [15:0] ptr_of(input int p, input int w);
    return 16'((p << 6) | (w << 1));
  endfunction : ptr_of

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(negedge mclk);
    d = sw_rdata;
  endtask : sw_read

  // One command, then poll until core and sequencer are both idle
  task automatic cmd(input logic [15:0] ptr, input logic [15:0] data, input logic [15:0] ctl);
    logic [15:0] q;
    logic [15:0] s;
    int n;
    sw_write(`HREG_PTR, ptr);
    sw_write(`HREG_DATA, data);
    sw_write(`HREG_CTL, ctl);
    repeat (2) @(posedge mclk);
    n = 0;
    do begin
      sw_read(`HREG_SEQ, q);
      sw_read(`HREG_STATUS, s);
      n++;
    end while ((q[0] !== 1'b0 || s[0] !== 1'b0) && n < 60);
    if (n == 60) chk({14'h0, q[0], s[0]}, 16'h0000);
  endtask : cmd

  // Reads settle within a few cycles of the request
  task automatic frd(input int wa, output logic [15:0] d);
    sw_write(`HREG_RADDR, 16'(wa));
    repeat (3) @(posedge mclk);
    sw_read(`HREG_RDATA, d);
  endtask : frd

  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog, far beyond the expected run
  initial begin
    #(50 * 60000);
    fails++;
    end_sim();
  end

  // Main sequence
  initial begin
    int i;
    int m;
    int p;
    int w;
    logic [15:0] v;
    void'($urandom(32'h8d15));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    sw_read(`HREG_STATUS, v);
    chk(v, 16'h0000);
    // Fill before erase (page 3) and after it (page 4), scattered order
    for (p = 3; p <= 4; p++) begin
      if (p == 4) cmd(ptr_of(p, 0), 16'h0000, 16'h0003);
      for (i = 0; i < 32; i++) begin
        w = (i * (p == 3 ? 7 : 5) + 3) % 32;
        exp_mem[w] = 16'($urandom);
        cmd(ptr_of(p, w) | 16'h0001, exp_mem[w], 16'h0001);
      end
      sw_read(`HREG_STATUS, v);
      chk(v & 16'h0040, 16'h0000);
      if (p == 3) cmd(ptr_of(p, 0) | 16'h003f, 16'h5a5a, 16'h0003);
      halt_cycles = 0;
      cmd(ptr_of(p, 0), 16'h0000, 16'h0005);
      chk(16'(halt_cycles), 16'h0000);
      sw_read(`HREG_STATUS, v);
      chk(v, 16'h0040);
      frd(p * 32 + 1, v);
      chk(v, 16'hffff);
      cmd(16'h0000, 16'h0000, 16'h0011);
      for (w = 0; w < 32; w++) begin
        frd(p * 32 + w, v);
        chk(v, exp_mem[w]);
      end
    end
    // Buffer kept, then cleared by write, EEPROM write, re-enable, reset
    for (m = 0; m < 5; m++) begin
      p = 10 + modes[m];
      if (modes[m] != 3) begin
        for (w = 0; w < 4; w++) cmd(ptr_of(p, w), 16'(16'h1110 + w), 16'h0001);
      end
      if (modes[m] == 1) begin
        @(posedge mclk) eeprom_busy <= 1'b1;
        cmd(ptr_of(p, 5), 16'h5555, 16'h0001);
        @(posedge mclk) eeprom_busy <= 1'b0;
      end
      if (modes[m] == 2) cmd(16'h0000, 16'h0000, 16'h0011);
      if (modes[m] == 4) begin
        @(posedge mclk) reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
      end
      cmd(ptr_of(p, 0), 16'h0000, 16'h0003);
      cmd(ptr_of(p, 0), 16'h0000, 16'h0005);
      cmd(16'h0000, 16'h0000, 16'h0011);
      for (w = 0; w < 4; w++) begin
        frd(p * 32 + w, v);
        chk(v, modes[m] == 0 ? 16'(16'h1110 + w) : 16'hffff);
      end
    end
    // Halting region: erase and write stall the core, no region busy
    cmd(ptr_of(100, 0), 16'h00a5, 16'h0001);
    for (i = 3; i <= 5; i += 2) begin
      halt_cycles = 0;
      cmd(ptr_of(100, 0), 16'h0000, 16'(i));
      chk(16'(halt_cycles > 0), 16'h0001);
    end
    frd(100 * 32, v);
    chk(v, 16'h00a5);
    sw_read(`HREG_STATUS, v);
    chk(v, 16'h0000);
    // Boot section write refused while the lock bit is programmed
    cmd(ptr_of(112, 0), 16'h0000, 16'h0003);
    cmd(ptr_of(112, 0), 16'h1234, 16'h0001);
    @(posedge mclk) boot_lock11 <= 1'b0;
    cmd(ptr_of(112, 0), 16'h0000, 16'h0005);
    @(posedge mclk) boot_lock11 <= 1'b1;
    frd(112 * 32, v);
    chk(v, 16'hffff);
    cmd(16'h0000, 16'h0000, 16'h0011);
    // A write with no erase of the same page before it is held back in the core
    cmd(ptr_of(7, 0), 16'h0000, 16'h0005);
    sw_read(`HREG_SEQ, v);
    chk(v & 16'h0004, 16'h0004);
    // Undefined patterns, then the ready request around an erase
    for (i = 0; i < 4; i++) begin
      cmd(16'h0000, 16'h0000, 16'(ill[i]));
      sw_read(`HREG_STATUS, v);
      chk(v, 16'h0000);
    end
    // Lock pattern is accepted, consumes its store and leaves nothing set
    cmd(16'h0000, 16'h00ff, 16'h0009);
    sw_read(`HREG_STATUS, v);
    chk(v, 16'h0000);
    // Ready request is polled, never vectored, so no fetch hits a busy region
    cmd(16'h0000, 16'h0000, 16'h0080);
    sw_read(`HREG_SEQ, v);
    chk(v & 16'h0010, 16'h0010);
    cmd(ptr_of(6, 0), 16'h0000, 16'h0083);
    sw_read(`HREG_STATUS, v);
    chk(v, 16'h00c0);
    cmd(16'h0000, 16'h0000, 16'h0091);
    sw_read(`HREG_STATUS, v);
    chk(v, 16'h0080);
    end_sim();
  end
endmodule : flash_self_program_sequencer_bench
`default_nettype wire
